// ### core/gdp_core.sv
// Gate driver control and protection core
module gdp_core
	import gdp_pkg::*;
#(
	parameter int PROG_TIMEOUT_CYCLES = PROG_MAX_CYCLES,
	parameter int ALARM_HOLD_CYCLES = ALARM_LATCH_CYCLES,
	parameter int OC_CONFIRM = OC_CONFIRM_CYCLES
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic drive_in,
	input wire logic chip_select_n,
	input wire logic undervoltage_alarm_in,
	input wire logic current_sense_a_fixed,
	input wire logic current_sense_a_ramp,
	input wire logic current_sense_b_fixed,
	input wire logic current_sense_b_ramp,
	input wire logic gate_above_plateau,
	input wire logic gate_above_clamp,
	input wire logic sec_temp_above_high,
	input wire logic sec_temp_below_low,
	input wire logic pri_temp_above_high,
	input wire logic pri_temp_below_low,
	input wire logic active_short_above_rise,
	input wire logic active_short_below_fall,
	input wire logic remote_overtemperature_fault,
	input wire logic gate_low_fault,
	input wire logic secondary_supply_lockout,
	input wire logic primary_supply_lockout,
	input wire logic memory_error,
	input wire logic program_pending_set,
	input wire logic nvm_write_done,
	input wire logic trim_preview_enable,
	input wire logic threshold_fixed_stored,
	input wire logic threshold_fixed_preview,
	output logic program_pending_bit,
	output logic nvm_write_start,
	output logic nvm_reload,
	output logic threshold_fixed_select,
	output logic serial_port_active,
	output logic gate_turn_on,
	output logic gate_turn_off,
	output logic gate_soft_off,
	output logic two_level_hold,
	output logic miller_clamp_on,
	output logic main_alarm_n,
	output logic driver_alarm_out_oe,
	output logic undervoltage_alarm_out_oe,
	output logic active_short_command,
	output logic thermal_shutdown
);

	localparam int PW = $clog2(PROG_TIMEOUT_CYCLES + 1);
	localparam int LW = $clog2(ALARM_HOLD_CYCLES + 1);
	localparam int OW = $clog2(OC_CONFIRM + 1);
	localparam logic [PW-1:0] PROG_LAST = PW'(PROG_TIMEOUT_CYCLES - 1);
	localparam logic [LW-1:0] LATCH_LOAD = LW'(ALARM_HOLD_CYCLES);
	localparam logic [OW-1:0] OC_LAST = OW'(OC_CONFIRM - 1);

	generate
		if (PROG_TIMEOUT_CYCLES < 1 || ALARM_HOLD_CYCLES < 1 ||
				OC_CONFIRM < 1) begin : g_bad_counts
			$error("gdp_core: cycle counts must be at least 1");
		end
	endgenerate

	typedef struct packed {
		gdp_oc_state_type oc_state;
		logic [OW-1:0] oc_cnt;
		logic [LW-1:0] latch_cnt;
		logic [PW-1:0] prog_cnt;
		logic prog_pend;
		logic nvm_start;
		logic nvm_reload;
		logic preview_prev;
		logic thr_fixed;
		logic sec_tsd;
		logic pri_tsd;
		logic asc_on;
		logic clamp;
		logic cmd_prev;
		logic spi_active;
		logic turn_on;
		logic turn_off;
		logic soft_off;
		logic two_level;
		logic alarm_n;
		logic drv_oe;
		logic uv_oe;
	} gdp_core_state_type;

	gdp_core_state_type state_r;
	gdp_core_state_type state_nxt;

	logic [IN_COUNT-1:0] raw_in;
	logic [IN_COUNT-1:0] syn;

	// Pins and comparator results enter through two flip-flops
	// Select, alarm wire and clamp compare enter inverted, so the cleared
	// synchroniser reads as idle after reset and fakes no session or latch
	assign raw_in[IN_DRIVE] = drive_in;
	assign raw_in[IN_CS_N] = !chip_select_n;
	assign raw_in[IN_UV_PIN] = !undervoltage_alarm_in;
	assign raw_in[IN_OCA_FIXED] = current_sense_a_fixed;
	assign raw_in[IN_OCA_RAMP] = current_sense_a_ramp;
	assign raw_in[IN_OCB_FIXED] = current_sense_b_fixed;
	assign raw_in[IN_OCB_RAMP] = current_sense_b_ramp;
	assign raw_in[IN_GATE_PLATEAU] = gate_above_plateau;
	assign raw_in[IN_GATE_CLAMP] = !gate_above_clamp;
	assign raw_in[IN_SEC_HOT] = sec_temp_above_high;
	assign raw_in[IN_SEC_COOL] = sec_temp_below_low;
	assign raw_in[IN_PRI_HOT] = pri_temp_above_high;
	assign raw_in[IN_PRI_COOL] = pri_temp_below_low;
	assign raw_in[IN_ASC_RISE] = active_short_above_rise;
	assign raw_in[IN_ASC_FALL] = active_short_below_fall;
	assign raw_in[IN_REMOTE_OT] = remote_overtemperature_fault;
	assign raw_in[IN_GATE_LOW] = gate_low_fault;
	assign raw_in[IN_SEC_LOCKOUT] = secondary_supply_lockout;
	assign raw_in[IN_PRI_LOCKOUT] = primary_supply_lockout;
	assign raw_in[IN_MEM_ERR] = memory_error;

	gdp_sync #(
		.WIDTH(IN_COUNT)
	) u_sync (
		.ref_clk(ref_clk),
		.reset(reset),
		.async_in(raw_in),
		.sync_out(syn)
	);

	// Hysteresis latch: set by the upper comparator, cleared by the lower
	function automatic logic hyst(input logic cur, input logic above,
			input logic below);
		hyst = above ? 1'b1 : (below ? 1'b0 : cur);
	endfunction

	// Working signals of the next-state logic
	logic spi_now;
	logic thr_fixed_now;
	logic oc_now;
	logic latched_fault;
	logic fault_now;
	logic fault_hold;
	logic fwd_cmd;
	logic cmd;
	logic cmd_rise;
	logic prog_done;

	always_comb begin
		state_nxt = state_r;
		spi_now = 1'b0;
		thr_fixed_now = 1'b0;
		oc_now = 1'b0;
		latched_fault = 1'b0;
		fault_now = 1'b0;
		fault_hold = 1'b0;
		fwd_cmd = 1'b0;
		cmd = 1'b0;
		cmd_rise = 1'b0;
		prog_done = 1'b0;

		// Serial port: select low and alarm pin low, pin not our own pull
		spi_now = syn[IN_CS_N] && syn[IN_UV_PIN] &&
			!state_r.uv_oe;
		state_nxt.spi_active = spi_now;

		// Memory write handshake; a set while the bit is pending is ignored
		state_nxt.nvm_start = program_pending_set && !state_r.prog_pend;
		prog_done = nvm_write_done ||
			(state_r.prog_pend && state_r.prog_cnt == PROG_LAST);
		if (program_pending_set && !state_r.prog_pend) begin
			state_nxt.prog_pend = 1'b1;
			state_nxt.prog_cnt = '0;
		end else if (state_r.prog_pend && prog_done) begin
			state_nxt.prog_pend = 1'b0;
			state_nxt.prog_cnt = '0;
		end else if (state_r.prog_pend) begin
			state_nxt.prog_cnt = state_r.prog_cnt + PW'(1);
		end

		// Settings source: stored values unless preview is on
		thr_fixed_now = trim_preview_enable ? threshold_fixed_preview
			: threshold_fixed_stored;
		state_nxt.thr_fixed = thr_fixed_now;
		state_nxt.preview_prev = trim_preview_enable;
		state_nxt.nvm_reload = state_r.preview_prev &&
			!trim_preview_enable;

		// Threshold choice for both sense inputs
		oc_now = thr_fixed_now
			? (syn[IN_OCA_FIXED] || syn[IN_OCB_FIXED])
			: (syn[IN_OCA_RAMP] || syn[IN_OCB_RAMP]);

		// Thermal shutdowns and active short with hysteresis
		state_nxt.sec_tsd = hyst(state_r.sec_tsd, syn[IN_SEC_HOT],
			syn[IN_SEC_COOL]);
		state_nxt.pri_tsd = hyst(state_r.pri_tsd, syn[IN_PRI_HOT],
			syn[IN_PRI_COOL]);
		state_nxt.asc_on = hyst(state_r.asc_on, syn[IN_ASC_RISE],
			syn[IN_ASC_FALL]);

		// Faults that latch the main alarm
		latched_fault = state_r.sec_tsd || syn[IN_REMOTE_OT] ||
			syn[IN_SEC_LOCKOUT] || syn[IN_MEM_ERR] ||
			state_r.oc_state == OC_FAULT;
		fault_now = latched_fault || syn[IN_GATE_LOW];
		if (latched_fault) begin
			state_nxt.latch_cnt = LATCH_LOAD;
		end else if (state_r.latch_cnt != '0) begin
			state_nxt.latch_cnt = state_r.latch_cnt - LW'(1);
		end
		fault_hold = fault_now || state_r.latch_cnt != '0;

		// Forward path, blocked by serial traffic and primary shutdowns
		fwd_cmd = syn[IN_DRIVE] && !spi_now && !syn[IN_PRI_LOCKOUT] &&
			!state_r.pri_tsd;
		cmd = fwd_cmd || state_r.asc_on;
		state_nxt.cmd_prev = cmd;
		cmd_rise = cmd && !state_r.cmd_prev;

		// Overcurrent two-level turn-off and confirm timer
		unique case (state_r.oc_state)
			OC_NORMAL: begin
				state_nxt.oc_cnt = '0;
				if (oc_now && cmd && !fault_hold) begin
					state_nxt.oc_state = OC_TWO_LEVEL;
				end
			end
			OC_TWO_LEVEL: begin
				if (!oc_now) begin
					state_nxt.oc_state = OC_NORMAL;
					state_nxt.oc_cnt = '0;
				end else if (state_r.oc_cnt == OC_LAST) begin
					state_nxt.oc_state = OC_FAULT;
					state_nxt.oc_cnt = '0;
				end else begin
					state_nxt.oc_cnt = state_r.oc_cnt + OW'(1);
				end
			end
			OC_FAULT: begin
				state_nxt.oc_cnt = '0;
				if (!oc_now) begin
					state_nxt.oc_state = OC_NORMAL;
				end
			end
			default: begin
				state_nxt.oc_state = OC_NORMAL;
				state_nxt.oc_cnt = '0;
			end
		endcase
		if (state_nxt.nvm_reload) begin
			state_nxt.oc_state = OC_NORMAL;
			state_nxt.oc_cnt = '0;
		end

		// Gate stage outputs
		state_nxt.two_level = state_r.oc_state == OC_TWO_LEVEL &&
			!fault_hold;
		state_nxt.soft_off = fault_hold;
		state_nxt.turn_on = cmd && !fault_hold &&
			state_r.oc_state == OC_NORMAL;
		if (fault_hold) begin
			state_nxt.turn_off = 1'b0;
		end else if (state_r.oc_state == OC_TWO_LEVEL) begin
			state_nxt.turn_off = syn[IN_GATE_PLATEAU];
		end else begin
			state_nxt.turn_off = !cmd;
		end

		// Miller clamp: latch below threshold, release on rising input
		if (fault_hold || cmd_rise || cmd) begin
			state_nxt.clamp = 1'b0;
		end else if (syn[IN_GATE_CLAMP]) begin
			state_nxt.clamp = 1'b1;
		end

		// Alarm pins; driver and undervoltage pins muted while select is low
		state_nxt.alarm_n = !(latched_fault ||
			state_r.latch_cnt != '0);
		state_nxt.drv_oe = !syn[IN_CS_N] && (syn[IN_GATE_LOW] ||
			syn[IN_MEM_ERR] || state_r.oc_state == OC_FAULT ||
			state_r.asc_on);
		state_nxt.uv_oe = !syn[IN_CS_N] && (syn[IN_GATE_LOW] ||
			syn[IN_SEC_LOCKOUT]);
	end

	// Reset brings the gate to a defined off state
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_r <= '0;
			state_r.oc_state <= OC_NORMAL;
			state_r.alarm_n <= 1'b1;
			state_r.turn_off <= 1'b1;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Every output is a field of the state register
	assign program_pending_bit = state_r.prog_pend;
	assign nvm_write_start = state_r.nvm_start;
	assign nvm_reload = state_r.nvm_reload;
	assign threshold_fixed_select = state_r.thr_fixed;
	assign serial_port_active = state_r.spi_active;
	assign gate_turn_on = state_r.turn_on;
	assign gate_turn_off = state_r.turn_off;
	assign gate_soft_off = state_r.soft_off;
	assign two_level_hold = state_r.two_level;
	assign miller_clamp_on = state_r.clamp;
	assign main_alarm_n = state_r.alarm_n;
	assign driver_alarm_out_oe = state_r.drv_oe;
	assign undervoltage_alarm_out_oe = state_r.uv_oe;
	assign active_short_command = state_r.asc_on;
	assign thermal_shutdown = state_r.sec_tsd;

endmodule

// ### core/gdp_pkg.sv
// What this block does
// - Hardware clears pending bit within 40 ms
// - Preview off: written registers have no effect
// - Preview on: written values steer the driver
// - Preview off again: reload stored values, restart
// - Serial port needs alarm pin and select low
// - Serial traffic blocks forward drive path
// - Select low forces both alarm pins high
// - Listed faults force the driver off
// - Primary supply lockout stops drive, gate low
// - Fault uses soft turn-off, alarm low except for gate low fault
// - No Miller clamp while fault active
// - Overcurrent starts two-level turn-off, confirm fault
// - Overcurrent gone early: turn on again, reset
// - Threshold fixed 2 V or temperature ramp
// - Two-level pulls gate down to plateau, holds
// - Clamp latches below 2 V until input rises
// - Secondary shutdown above 150, exit below 130
// - Primary shutdown above 154, exit below 135
// - Active short ORed with drive, hysteresis comparator
// - Serial memory access stays open during short
// - Main alarm held at least 20 ms
package gdp_pkg;

	// Clock and timing
	localparam int CLK_HZ = 100_000_000;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	localparam int PROG_MAX_MS = 40;
	localparam int PROG_MAX_CYCLES = PROG_MAX_MS * CYC_PER_MS;
	localparam int ALARM_LATCH_MS = 20;
	localparam int ALARM_LATCH_CYCLES = ALARM_LATCH_MS * CYC_PER_MS;
	localparam int OC_CONFIRM_NS = 2000;
	localparam int OC_CONFIRM_CYCLES = OC_CONFIRM_NS / (1_000_000_000 / CLK_HZ);
	localparam int SYNC_STAGES = 2;

	// Bit positions of the synchronised pin and comparator vector
	localparam int IN_DRIVE = 0;
	localparam int IN_CS_N = 1;
	localparam int IN_UV_PIN = 2;
	localparam int IN_OCA_FIXED = 3;
	localparam int IN_OCA_RAMP = 4;
	localparam int IN_OCB_FIXED = 5;
	localparam int IN_OCB_RAMP = 6;
	localparam int IN_GATE_PLATEAU = 7;
	localparam int IN_GATE_CLAMP = 8;
	localparam int IN_SEC_HOT = 9;
	localparam int IN_SEC_COOL = 10;
	localparam int IN_PRI_HOT = 11;
	localparam int IN_PRI_COOL = 12;
	localparam int IN_ASC_RISE = 13;
	localparam int IN_ASC_FALL = 14;
	localparam int IN_REMOTE_OT = 15;
	localparam int IN_GATE_LOW = 16;
	localparam int IN_SEC_LOCKOUT = 17;
	localparam int IN_PRI_LOCKOUT = 18;
	localparam int IN_MEM_ERR = 19;
	localparam int IN_COUNT = 20;

	// Overcurrent turn-off sequence
	typedef enum logic [2:0] {
		OC_NORMAL = 3'h1,
		OC_TWO_LEVEL = 3'h2,
		OC_FAULT = 3'h4
	} gdp_oc_state_type;

endpackage

// ### core/gdp_sync.sv
// Two-stage synchroniser for a vector of independent levels
module gdp_sync #(
	parameter int WIDTH = 1
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} gdp_sync_state_type;

	gdp_sync_state_type state_r;
	gdp_sync_state_type state_nxt;

	generate
		if (WIDTH < 1) begin : g_bad_width
			$error("gdp_sync: WIDTH must be at least 1");
		end
	endgenerate

	// Stage one feeds only stage two
	always_comb begin
		state_nxt = state_r;
		state_nxt.stage1 = async_in;
		state_nxt.stage2 = state_r.stage1;
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign sync_out = state_r.stage2;

endmodule

// ### verification/gate_driver_protection_control_tb_top.sv
// Directed bench for the protection core
module gate_driver_protection_control_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk, reset, current_sense_a_fixed, current_sense_a_ramp;
	logic current_sense_b_fixed, current_sense_b_ramp, gate_above_plateau;
	logic gate_above_clamp, sec_temp_above_high, sec_temp_below_low;
	logic pri_temp_above_high, pri_temp_below_low, active_short_above_rise;
	logic active_short_below_fall, remote_overtemperature_fault;
	logic gate_low_fault, secondary_supply_lockout, primary_supply_lockout;
	logic memory_error, nvm_write_done, trim_preview_enable;
	logic threshold_fixed_stored, threshold_fixed_preview, drive_in;
	logic chip_select_n, undervoltage_alarm_in, program_pending_set;
	logic program_pending_bit, nvm_write_start, nvm_reload;
	logic threshold_fixed_select, serial_port_active, gate_turn_on;
	logic gate_turn_off, gate_soft_off, two_level_hold, miller_clamp_on;
	logic main_alarm_n, driver_alarm_out_oe, undervoltage_alarm_out_oe;
	logic active_short_command, thermal_shutdown;
	int miscompares = 0;
	int compares = 0;
	int cyc = 0;
	// Short counts keep the run brief
	gdp_core #(.PROG_TIMEOUT_CYCLES(50), .ALARM_HOLD_CYCLES(20),
		.OC_CONFIRM(5)) DUT (.*);
	gdp_host host (.*);
	// Clock
	initial begin
		ref_clk = 1'h0;
		forever #5 ref_clk = ~ref_clk;
	end
	// Wait cycles, then land just after the edge
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	// Compare one output bit
	task automatic chk(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %b exp %b", $time, got, exp);
		end
	endtask
	// Verdict
	task automatic test_done();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Hang guard
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			miscompares++;
			test_done();
		end
	end
	// Main sequence
	initial begin
		reset = 1'h1;
		{current_sense_a_fixed, current_sense_a_ramp} = 2'h0;
		{current_sense_b_fixed, current_sense_b_ramp} = 2'h0;
		{sec_temp_above_high, sec_temp_below_low} = 2'h1;
		{pri_temp_above_high, pri_temp_below_low} = 2'h1;
		{active_short_above_rise, active_short_below_fall} = 2'h1;
		{gate_above_plateau, gate_above_clamp} = 2'h3;
		{nvm_write_done, trim_preview_enable} = 2'h0;
		{threshold_fixed_stored, threshold_fixed_preview} = 2'h1;
		{remote_overtemperature_fault, gate_low_fault} = 2'h0;
		{secondary_supply_lockout, memory_error} = 2'h0;
		primary_supply_lockout = 1'h0;
		step(6);
		reset = 1'h0;
		step(6);
		chk(threshold_fixed_select, 1'h0);
		chk(miller_clamp_on, 1'h0);
		trim_preview_enable = 1'h1;
		step(2);
		chk(threshold_fixed_select, 1'h1);
		trim_preview_enable = 1'h0;
		step(1);
		chk(nvm_reload, 1'h1);
		step(1);
		chk(nvm_reload, 1'h0);
		chk(threshold_fixed_select, 1'h0);
		// Write finished by the memory; a repeat request is ignored
		host.prog();
		chk(program_pending_bit, 1'h1);
		chk(nvm_write_start, 1'h1);
		step(1);
		host.prog();
		chk(nvm_write_start, 1'h0);
		step(3);
		nvm_write_done = 1'h1;
		step(1);
		nvm_write_done = 1'h0;
		chk(program_pending_bit, 1'h0);
		// Select low with the wire high keeps the port shut
		host.drive(1'h1);
		host.pins(1'h0, 1'h0);
		step(6);
		chk(serial_port_active, 1'h0);
		chk(gate_turn_on, 1'h1);
		host.pins(1'h1, 1'h0);
		step(5);
		chk(serial_port_active, 1'h1);
		chk(gate_turn_on, 1'h0);
		// Active short drives through the session; writes still run
		{active_short_above_rise, active_short_below_fall} = 2'h2;
		step(5);
		chk(active_short_command, 1'h1);
		chk(gate_turn_on, 1'h1);
		active_short_above_rise = 1'h0;
		host.prog();
		chk(program_pending_bit, 1'h1);
		step(45);
		chk(program_pending_bit, 1'h1);
		chk(active_short_command, 1'h1);
		step(10);
		chk(program_pending_bit, 1'h0);
		active_short_below_fall = 1'h1;
		step(5);
		chk(active_short_command, 1'h0);
		chk(gate_turn_on, 1'h0);
		// Fault stays off the pins while selected
		gate_low_fault = 1'h1;
		step(5);
		chk(driver_alarm_out_oe, 1'h0);
		chk(undervoltage_alarm_out_oe, 1'h0);
		host.pins(1'h0, 1'h1);
		step(5);
		chk(driver_alarm_out_oe, 1'h1);
		chk(undervoltage_alarm_out_oe, 1'h1);
		gate_low_fault = 1'h0;
		step(30);
		// Each listed fault or lockout turns the driver off
		for (int i = 0; i < 5; i++) begin
			{remote_overtemperature_fault, gate_low_fault,
				secondary_supply_lockout, memory_error,
				primary_supply_lockout} = 5'h10 >> i;
			step(5);
			chk(gate_turn_on, 1'h0);
			chk(gate_soft_off, i != 4);
			chk(main_alarm_n, i == 1 || i == 4);
			{remote_overtemperature_fault, gate_low_fault} = 2'h0;
			{secondary_supply_lockout, memory_error} = 2'h0;
			primary_supply_lockout = 1'h0;
			step(6);
			chk(main_alarm_n, i == 1 || i == 4);
			step(25);
			chk(gate_turn_on, 1'h1);
		end
		// Secondary then primary thermal shutdown with hysteresis
		{sec_temp_above_high, sec_temp_below_low} = 2'h2;
		step(5);
		chk(thermal_shutdown, 1'h1);
		chk(gate_soft_off, 1'h1);
		chk(main_alarm_n, 1'h0);
		sec_temp_above_high = 1'h0;
		step(5);
		chk(thermal_shutdown, 1'h1);
		sec_temp_below_low = 1'h1;
		step(30);
		chk(thermal_shutdown, 1'h0);
		{pri_temp_above_high, pri_temp_below_low} = 2'h2;
		step(5);
		chk(gate_turn_off, 1'h1);
		pri_temp_above_high = 1'h0;
		step(5);
		chk(gate_turn_on, 1'h0);
		pri_temp_below_low = 1'h1;
		step(5);
		chk(gate_turn_on, 1'h1);
		// Ramp threshold chosen: fixed comparator alone is ignored
		current_sense_a_fixed = 1'h1;
		step(6);
		chk(two_level_hold, 1'h0);
		current_sense_a_fixed = 1'h0;
		current_sense_b_ramp = 1'h1;
		step(4);
		chk(two_level_hold, 1'h1);
		chk(gate_turn_off, 1'h1);
		current_sense_b_ramp = 1'h0;
		step(8);
		chk(gate_turn_on, 1'h1);
		chk(main_alarm_n, 1'h1);
		// Stored fixed threshold: ramp result ignored, fixed one acts
		{threshold_fixed_stored, threshold_fixed_preview} = 2'h2;
		current_sense_b_ramp = 1'h1;
		step(6);
		chk(threshold_fixed_select, 1'h1);
		chk(two_level_hold, 1'h0);
		current_sense_b_ramp = 1'h0;
		current_sense_b_fixed = 1'h1;
		step(4);
		chk(two_level_hold, 1'h1);
		current_sense_b_fixed = 1'h0;
		{threshold_fixed_stored, threshold_fixed_preview} = 2'h1;
		step(8);
		chk(gate_turn_on, 1'h1);
		// Lasting overcurrent below the plateau becomes a fault
		{current_sense_a_ramp, gate_above_plateau} = 2'h2;
		step(4);
		chk(gate_turn_off, 1'h0);
		step(6);
		chk(gate_soft_off, 1'h1);
		chk(main_alarm_n, 1'h0);
		host.drive(1'h0);
		gate_above_clamp = 1'h0;
		step(5);
		chk(miller_clamp_on, 1'h0);
		{current_sense_a_ramp, gate_above_plateau} = 2'h1;
		step(30);
		chk(miller_clamp_on, 1'h1);
		gate_above_clamp = 1'h1;
		step(5);
		chk(miller_clamp_on, 1'h1);
		host.drive(1'h1);
		step(5);
		chk(miller_clamp_on, 1'h0);
		test_done();
	end
endmodule

// ### verification/gdp_core_chk.sv
// Port-level relations of the protection core
module gdp_chk
	import gdp_pkg::*;
#(
	parameter int PROG_TIMEOUT_CYCLES = PROG_MAX_CYCLES,
	parameter int OC_CONFIRM = OC_CONFIRM_CYCLES
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic program_pending_set,
	input wire logic nvm_write_done,
	input wire logic trim_preview_enable,
	input wire logic threshold_fixed_stored,
	input wire logic threshold_fixed_preview,
	input wire logic program_pending_bit,
	input wire logic nvm_write_start,
	input wire logic nvm_reload,
	input wire logic threshold_fixed_select,
	input wire logic serial_port_active,
	input wire logic gate_turn_on,
	input wire logic gate_soft_off,
	input wire logic two_level_hold,
	input wire logic miller_clamp_on,
	input wire logic main_alarm_n,
	input wire logic driver_alarm_out_oe,
	input wire logic undervoltage_alarm_out_oe,
	input wire logic active_short_command
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int OC_WIN = OC_CONFIRM + 3;
	int pend_cnt_r;
	// Counts cycles of a pending write
	always_ff @(posedge ref_clk) begin
		if (reset || !program_pending_bit)
			pend_cnt_r <= 0;
		else
			pend_cnt_r <= pend_cnt_r + 1;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	// Memory write handshake
	chk_write_start: assert property (
		program_pending_set && !program_pending_bit
		|=> program_pending_bit && nvm_write_start)
		else $error("write request not started");
	chk_write_done: assert property (
		nvm_write_done && program_pending_bit |=> !program_pending_bit)
		else $error("pending bit not cleared after done");
	chk_write_bound: assert property (
		pend_cnt_r <= PROG_TIMEOUT_CYCLES + 1)
		else $error("pending bit held past the limit");
	// Preview selection
	chk_preview_sel: assert property (
		1'h1 |=> threshold_fixed_select == ($past(trim_preview_enable)
		? $past(threshold_fixed_preview) : $past(threshold_fixed_stored)))
		else $error("threshold setting from wrong source");
	chk_reload_pulse: assert property (
		$fell(trim_preview_enable) |=> nvm_reload)
		else $error("no reload after preview ended");
	// Serial session
	chk_serial_quiet: assert property (
		serial_port_active |-> !driver_alarm_out_oe
		&& !undervoltage_alarm_out_oe)
		else $error("alarm pin pulled during session");
	chk_serial_block: assert property (
		serial_port_active && $past(serial_port_active)
		&& !active_short_command && !$past(active_short_command)
		|-> !gate_turn_on)
		else $error("drive passed during session");
	// Fault shutdown
	chk_fault_soft: assert property (
		$fell(main_alarm_n) |-> gate_soft_off && !gate_turn_on)
		else $error("alarm without soft turn-off");
	chk_alarm_hold: assert property (
		$fell(main_alarm_n) |-> !main_alarm_n [*8])
		else $error("main alarm released too early");
	chk_clamp_fault: assert property (
		gate_soft_off |-> !miller_clamp_on)
		else $error("clamp on during fault");
	chk_two_level: assert property (
		$rose(two_level_hold) |-> !gate_turn_on
		##[1:OC_WIN] !two_level_hold)
		else $error("two-level phase wrong");
	// Main scenarios reached
	cover property (nvm_write_start);
	cover property ($fell(main_alarm_n));
	cover property ($rose(two_level_hold));
	cover property (serial_port_active && active_short_command);
endmodule

bind gdp_core gdp_chk #(
	.PROG_TIMEOUT_CYCLES(PROG_TIMEOUT_CYCLES),
	.OC_CONFIRM(OC_CONFIRM)
) chk_i (.*);

// ### verification/gdp_host.sv
// Primary-side controller: drive pin, serial select and alarm wire
module gdp_host (
	input wire logic ref_clk,
	input wire logic undervoltage_alarm_out_oe,
	output logic drive_in,
	output logic chip_select_n,
	output wire logic undervoltage_alarm_in,
	output logic program_pending_set
);
	timeunit 1ns;
	timeprecision 1ps;
	logic uv_pull;
	// Alarm wire has a pull-up; low while either side pulls it
	assign undervoltage_alarm_in = !(uv_pull | undervoltage_alarm_out_oe);
	// Idle levels
	initial begin
		drive_in = 1'h0;
		chip_select_n = 1'h1;
		uv_pull = 1'h0;
		program_pending_set = 1'h0;
	end
	// One-cycle write request
	task automatic prog();
		program_pending_set = 1'h1;
		@(posedge ref_clk);
		#1 program_pending_set = 1'h0;
	endtask
	// Open-drain pull on the alarm wire and chip select
	task automatic pins(input logic pull, input logic cs_n);
		uv_pull = pull;
		chip_select_n = cs_n;
	endtask
	// Forward drive level
	task automatic drive(input logic lvl);
		drive_in = lvl;
	endtask
endmodule
